// File: verilog/muxed_bus_dma_master.sv
// bus-master end of a multiplexed address/data dma interface
// assumes: i_clk side gives one transfer at a time; the bus clock is the link clock

`timescale 1ns/1ps

module muxed_bus_dma_master
    import mux_dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    // user request side, i_clk domain
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic i_req_write,
    input wire logic i_req_word,
    input wire logic i_bus_8bit,
    input wire logic [DATA_W-1:0] i_req_wdata,
    output logic o_done,
    output logic [DATA_W-1:0] o_rd_data,
    // system bus side, system_bus_clock domain
    input wire logic i_system_bus_clock,
    output logic o_bus_hold_request,
    input wire logic i_hold_acknowledge,
    input wire logic i_bus_busy_in_n,
    input wire logic i_bus_error_in_n,
    output logic o_bus_owned_n,
    output logic [DATA_W-1:0] o_addr_data_bus,
    output logic o_addr_data_low_byte_oe,
    output logic o_addr_data_high_byte_oe,
    input wire logic [DATA_W-1:0] i_addr_data_bus,
    output logic o_data_direction,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic o_strobe_oe,
    output logic o_byte_high_enable_n,
    output logic o_byte_high_enable_oe,
    input wire logic i_byte_high_enable,
    output logic o_address_latch_enable,
    input wire logic i_slave_ready_n,
    output logic o_transceiver_enable_n
);

    // ------------------------------------------------------------
    // user side: job registers held stable while busy
    // ------------------------------------------------------------
    logic busy;                   // a job is out on the link
    logic req_tog;                // flips once per new job
    logic [ADDR_W-1:0] j_addr;    // job address
    logic j_write;                // job is a write
    logic j_word;                 // job is a word transfer
    logic j_mode8;                // 8-bit bus mode for this job
    logic [DATA_W-1:0] j_wdata;   // job write data, lane aligned
    logic done_pulse;             // job finished, i_clk pulse
    logic done_tog;               // flips once per finished job, link side
    logic [DATA_W-1:0] rdata;     // read data captured on the link
    logic take;                   // request accepted this cycle

    assign o_req_ready = ~busy;
    assign take = i_req_valid & ~busy;

    // completion returns from the link as a toggle
    toggle_pulse_sync u_done_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_toggle(done_tog),
        .o_pulse(done_pulse)
    );

    // accept one job, wait for its completion, return read data
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy <= 1'b0;
            req_tog <= 1'b0;
            j_addr <= '0;
            j_write <= 1'b0;
            j_word <= 1'b0;
            j_mode8 <= 1'b0;
            j_wdata <= '0;
            o_done <= 1'b0;
            o_rd_data <= '0;
        end else begin
            o_done <= done_pulse;
            if (take) begin
                // fields freeze here until the link reports back
                busy <= 1'b1;
                req_tog <= ~req_tog;
                j_addr <= i_req_addr;
                j_write <= i_req_write;
                j_word <= i_req_word;
                j_mode8 <= i_bus_8bit;
                j_wdata <= i_req_wdata;
            end else if (done_pulse) begin
                // read data is stable on the link side by now
                busy <= 1'b0;
                o_rd_data <= rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // link reset and start event
    // ------------------------------------------------------------
    logic rst_link_meta;  // reset release, first stage
    logic rst_link;       // reset for the bus clock domain
    logic start_pulse;    // new job seen on the link

    // asserted at once, released on the bus clock
    always_ff @(posedge i_system_bus_clock or posedge i_rst) begin
        if (i_rst) begin
            rst_link_meta <= 1'b1;
            rst_link <= 1'b1;
        end else begin
            rst_link_meta <= 1'b0;
            rst_link <= rst_link_meta;
        end
    end

    // job start crosses as a toggle
    toggle_pulse_sync u_req_sync (
        .i_clk(i_system_bus_clock),
        .i_rst(rst_link),
        .i_toggle(req_tog),
        .o_pulse(start_pulse)
    );

    // ------------------------------------------------------------
    // pin inputs, sampled on the falling bus clock edge
    // ------------------------------------------------------------
    logic [IN_SYNC_W-1:0] pin_raw;  // raw asynchronous pins
    logic [IN_SYNC_W-1:0] pin_s;    // after two falling-edge flops
    logic ack_s;                    // hold acknowledge
    logic busy_n_s;                 // bus busy, high when free
    logic err_n_s;                  // bus error, high when clean
    logic ready_n_s;                // slave ready, low when done
    logic bhe_pin_s;                // byte-high-enable pin level
    logic [DATA_W-1:0] ad_s;        // address/data bus level

    assign pin_raw = {i_hold_acknowledge, i_bus_busy_in_n, i_bus_error_in_n,
                      i_slave_ready_n, i_byte_high_enable, i_addr_data_bus};
    assign ack_s = pin_s[20];
    assign busy_n_s = pin_s[19];
    assign err_n_s = pin_s[18];
    assign ready_n_s = pin_s[17];
    assign bhe_pin_s = pin_s[16];
    assign ad_s = pin_s[15:0];

    // data and ready share one pipeline, so they stay aligned
    level_sync #(
        .WIDTH(IN_SYNC_W)
    ) u_pin_sync (
        .i_clk(~i_system_bus_clock),
        .i_rst(rst_link),
        .i_async(pin_raw),
        .o_sync(pin_s)
    );

    // ------------------------------------------------------------
    // byte lane decode
    // ------------------------------------------------------------
    logic lane_lo;   // low lane carries data
    logic lane_hi;   // high lane carries data
    logic bhe_val;   // byte-high-enable level for the transfer

    assign lane_lo = j_mode8 | j_word | ~j_addr[0];
    assign lane_hi = ~j_mode8 & (j_word | j_addr[0]);
    assign bhe_val = ~lane_hi;

    // ------------------------------------------------------------
    // rising-edge sequencer
    // ------------------------------------------------------------
    link_state_t state;  // current bus phase
    logic job_pend;      // job waiting for the bus
    logic hold_req;      // hold request level
    logic grant_ok;      // own request and three arbitration inputs seen high
    logic strobe_on;     // strobes driven from tx onward
    logic rd_act;        // read strobe asserted
    logic wr_act;        // write strobe asserted
    logic dir_rd;        // direction turned toward the device
    logic end_flag;      // slave finished, from the falling edge
    logic rel;           // bus being released, from the falling edge

    assign o_bus_hold_request = hold_req;

    // bus phases advance on the rising edge
    always_ff @(posedge i_system_bus_clock or posedge rst_link) begin
        if (rst_link) begin
            state <= ST_IDLE;
            job_pend <= 1'b0;
            hold_req <= 1'b0;
            o_bus_owned_n <= 1'b1;
            strobe_on <= 1'b0;
            rd_act <= 1'b0;
            wr_act <= 1'b0;
            dir_rd <= 1'b0;
            done_tog <= 1'b0;
        end else begin
            if (start_pulse) begin
                job_pend <= 1'b1;
            end
            unique case (state)
                ST_IDLE: begin
                    // wait for a job and for the last acknowledge to clear
                    if (job_pend && !ack_s) begin
                        hold_req <= 1'b1;
                        job_pend <= 1'b0;
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // first rising edge after a good sample
                    if (grant_ok) begin
                        state <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    // second rising edge: take the bus
                    o_bus_owned_n <= 1'b0;
                    state <= ST_I3;
                end
                ST_I3: begin
                    // tx high: direction and idle strobes
                    dir_rd <= ~j_write;
                    strobe_on <= 1'b1;
                    state <= ST_TX;
                end
                ST_TX: begin
                    // t1 high: strobe falls
                    wr_act <= j_write;
                    rd_act <= ~j_write;
                    state <= ST_T1;
                end
                ST_T1: begin
                    state <= ST_T2;
                end
                ST_T2: begin
                    state <= ST_T3;
                end
                ST_T3: begin
                    // stay in t3 until the slave is ready
                    if (end_flag) begin
                        state <= ST_T4;
                    end
                end
                ST_T4: begin
                    // i1 high: drop the request, report completion
                    hold_req <= 1'b0;
                    strobe_on <= 1'b0;
                    rd_act <= 1'b0;
                    wr_act <= 1'b0;
                    dir_rd <= 1'b0;
                    done_tog <= ~done_tog;
                    state <= ST_I1;
                end
                ST_I1: begin
                    // i2 high: give the bus back
                    o_bus_owned_n <= 1'b1;
                    state <= ST_I2;
                end
                ST_I2: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // falling-edge bus drive
    // ------------------------------------------------------------
    logic ale;      // address latch enable level
    logic t3_seen;  // one t3 has passed, synced bus now shows the slave

    assign o_address_latch_enable = ale;

    // address, data, byte enable and transceiver change on the falling edge
    always_ff @(negedge i_system_bus_clock or posedge rst_link) begin
        if (rst_link) begin
            grant_ok <= 1'b0;
            o_addr_data_bus <= AD_RESET;
            o_addr_data_low_byte_oe <= 1'b0;
            o_addr_data_high_byte_oe <= 1'b0;
            o_byte_high_enable_n <= 1'b1;
            o_byte_high_enable_oe <= 1'b0;
            o_transceiver_enable_n <= 1'b1;
            ale <= 1'b0;
            end_flag <= 1'b0;
            rel <= 1'b0;
            rdata <= '0;
            t3_seen <= 1'b0;
        end else begin
            // own request plus the three synchronised inputs
            grant_ok <= hold_req & ack_s & busy_n_s & err_n_s;
            // let go of byte-high-enable once it reads high
            if (rel && bhe_pin_s) begin
                o_byte_high_enable_oe <= 1'b0;
            end
            unique case (state)
                ST_I3: begin
                    // tx opens: extended and middle address
                    o_addr_data_bus <= {j_addr[15:8], j_addr[23:16]};
                    o_addr_data_low_byte_oe <= 1'b1;
                    o_addr_data_high_byte_oe <= 1'b1;
                    end_flag <= 1'b0;
                    t3_seen <= 1'b0;
                    rel <= 1'b0;
                end
                ST_TX: begin
                    // low address byte, byte enable, latch pulse
                    o_addr_data_bus <= {j_addr[15:8], j_addr[7:0]};
                    o_byte_high_enable_n <= bhe_val;
                    o_byte_high_enable_oe <= 1'b1;
                    ale <= 1'b1;
                end
                ST_T1: begin
                    // address latched: data phase begins
                    ale <= 1'b0;
                    o_transceiver_enable_n <= 1'b0;
                    o_addr_data_bus <= j_wdata;
                    o_addr_data_low_byte_oe <= j_write & lane_lo;
                    o_addr_data_high_byte_oe <= j_write & lane_hi;
                end
                ST_T3: begin
                    // end of t3: finish only when the slave is ready; a read
                    // repeats t3 once so the synced bus has lost our own address
                    t3_seen <= 1'b1;
                    if (!ready_n_s && (t3_seen || j_write)) begin
                        end_flag <= 1'b1;
                        rdata <= ad_s;
                    end
                end
                ST_T4: begin
                    // last transfer: float address/data and strobes, drive byte enable high
                    rel <= 1'b1;
                    o_addr_data_low_byte_oe <= 1'b0;
                    o_addr_data_high_byte_oe <= 1'b0;
                    o_byte_high_enable_n <= 1'b1;
                    o_transceiver_enable_n <= 1'b1;
                end
                default: begin
                    // other phases hold the bus drive
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // strobes and direction from both edges
    // ------------------------------------------------------------
    assign o_strobe_oe = strobe_on & ~rel;
    assign o_read_strobe_n = ~(rd_act & ~end_flag);
    assign o_write_strobe_n = ~(wr_act & ~end_flag);
    assign o_data_direction = ~(dir_rd & ~rel);

    // ------------------------------------------------------------
    // checks on the bus clock
    // ------------------------------------------------------------
    a_req_after_ack: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        $rose(hold_req) |-> !$past(ack_s))
        else $error("hold request raised while acknowledge still high");

    a_own_on_grant: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_REQ && grant_ok) |=> o_bus_owned_n ##1 !o_bus_owned_n)
        else $error("bus owned not taken on second rising edge");

    a_ext_address: assert property (
        @(negedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_I3) |=> (o_addr_data_bus == {j_addr[15:8], j_addr[23:16]})
            && o_addr_data_low_byte_oe && o_addr_data_high_byte_oe)
        else $error("extended address not driven at tx");

    a_read_direction: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_TX) |-> (o_data_direction == j_write) && o_strobe_oe
            && o_read_strobe_n && o_write_strobe_n)
        else $error("direction or idle strobes wrong in tx");

    a_write_strobe: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_T1) |-> (o_write_strobe_n == !j_write)
            && (o_read_strobe_n == j_write))
        else $error("strobe not asserted in t1");

    a_bus_release: assert property (
        @(negedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_T4) |=> !o_addr_data_low_byte_oe && !o_addr_data_high_byte_oe
            && !o_strobe_oe && o_data_direction && o_byte_high_enable_n)
        else $error("bus not released at t4");

    a_hold_drop: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_T4) |=> !hold_req && !o_bus_owned_n ##1 o_bus_owned_n)
        else $error("request and ownership not returned in order");

    a_ale_pulse: assert property (
        @(negedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_TX) |=> ale ##1 !ale)
        else $error("address latch pulse missing");

    a_wait_state: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        (state == ST_T3 && !end_flag) |=> (state == ST_T3))
        else $error("t3 not repeated while slave busy");

    a_bhe_8bit: assert property (
        @(posedge i_system_bus_clock) disable iff (rst_link)
        j_mode8 |-> o_byte_high_enable_n
            && (o_transceiver_enable_n || !o_addr_data_high_byte_oe))
        else $error("high lane used in 8-bit mode");

endmodule : muxed_bus_dma_master

// File: verilog/mux_dma_pkg.sv
// shared constants and types for the multiplexed-bus dma master
// assumes: imported whole by every design module of this block

package mux_dma_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;          // dma address width
    localparam int DATA_W = 16;          // address/data bus width
    localparam int IN_SYNC_W = 21;       // pin inputs sampled on the falling edge

    // ------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [15:0] AD_RESET = 16'h0000;  // bus output latch after reset
    localparam int IDLE_HANDOFF_MIN = 3;          // idle bus clocks in each handoff

    // ------------------------------------------------------------
    // link-side sequencer states, named by the bus-clock high phase
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_REQ,
        ST_SYNC,
        ST_I3,
        ST_TX,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_T4,
        ST_I1,
        ST_I2
    } link_state_t;

endpackage : mux_dma_pkg

// File: verilog/level_sync.sv
// two-flop synchroniser for a group of level signals
// assumes: each bit is a slow level or is qualified by a slower handshake

`timescale 1ns/1ps

module level_sync
    import mux_dma_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta;  // first stage, read only by the second

    // two flops in series, cleared by reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule : level_sync

// File: verilog/toggle_pulse_sync.sv
// carries an event from another clock as a toggle and returns a one-cycle pulse
// assumes: events are spaced by far more than three destination clocks

`timescale 1ns/1ps

module toggle_pulse_sync
    import mux_dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_toggle,
    output logic o_pulse
);

    // ------------------------------------------------------------
    // synchroniser and edge detector
    // ------------------------------------------------------------
    logic meta;   // first stage, read only by stage two
    logic stage;  // synchronised toggle
    logic last;   // previous synchronised toggle

    // each change of the toggle gives one pulse
    assign o_pulse = stage ^ last;

    // three flops: two to synchronise, one to remember
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= 1'b0;
            stage <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= i_toggle;
            stage <= meta;
            last <= stage;
        end
    end

endmodule : toggle_pulse_sync

// File: tb/bus_partner.sv
// far-side model: bus arbiter plus one memory slave with wait states
// assumes: strobes arrive already resolved against their pull-ups
`timescale 1ns/1ps
module bus_partner (
    input wire logic i_bclk,
    input wire logic i_hreq,
    input wire logic [15:0] i_ad,
    input wire logic i_lo_oe,
    input wire logic i_hi_oe,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_ale,
    input wire logic [1:0] i_waits,
    output logic o_ack,
    output logic o_ready_n,
    output logic [15:0] o_ad,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata
);
    logic [1:0] n = 2'h0; // wait states left
    logic [15:0] last = 16'h0000; // last bus level, inverted when floating
    wire [15:0] drv = {{8{i_hi_oe}}, {8{i_lo_oe}}};
    // read data is the inverted latched address
    assign o_ad = (drv & i_ad) | (~drv & (i_rd_n ? ~last : ~o_addr));
    // ready low once the wait count has run out
    assign o_ready_n = !(i_rd_n && i_wr_n) && n != 2'h0;
    // acknowledge follows request one clock later
    always @(posedge i_bclk) o_ack <= i_hreq;
    always @(posedge i_bclk) last <= o_ad;
    // load wait count when idle, count down while a strobe is low
    always @(posedge i_bclk) n <= (i_rd_n && i_wr_n) ? i_waits : n - (n != 2'h0);
    // transparent address latch, last bus clock edge inside the enable pulse
    always @(posedge i_bclk) if (i_ale) o_addr <= o_ad;
    // write data taken on the rising write strobe
    always @(posedge i_wr_n) o_wdata <= o_ad;
endmodule : bus_partner

// File: tb/testbench.sv
// self-checking bench: corner and random jobs through the bus model
// assumes: the bus clock runs free; busy and error are released within the test
`timescale 1ns/1ps
module testbench;
    import mux_dma_pkg::*;
    logic i_clk = 0, i_rst = 1, bclk = 0, req_valid = 0, req_write = 0, req_word = 0;
    logic bus_8bit = 0, req_ready, done, hreq, ack, owned_n, lo_oe, hi_oe, dir, rd_n;
    logic wr_n, sto_oe, bhe_n, bhe_oe, ale, rdy_n, xcvr_n, bhe_seen, dir_seen;
    logic xcvr_seen, busy_n = 1, err_n = 1;
    logic [23:0] req_addr = 0;
    logic [15:0] req_wdata = 0, rd_data, ad_out, ad_pin, addr_seen, wr_seen, ext_seen;
    logic [1:0] waits = 0, oe_seen, arb_seen;
    logic [31:0] seed = 32'h2543;
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    wire rd_pin = sto_oe ? rd_n : 1'b1; // strobes pulled up when floating
    wire wr_pin = sto_oe ? wr_n : 1'b1;
    wire bhe_pin = bhe_oe ? bhe_n : 1'b1;
    always #2.5 i_clk = ~i_clk;
    initial #7 forever #15 bclk = ~bclk;
    muxed_bus_dma_master muxed_bus_dma_master_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_addr(req_addr),
        .i_req_write(req_write), .i_req_word(req_word), .i_bus_8bit(bus_8bit),
        .i_req_wdata(req_wdata), .o_done(done), .o_rd_data(rd_data),
        .i_system_bus_clock(bclk), .o_bus_hold_request(hreq), .i_hold_acknowledge(ack),
        .i_bus_busy_in_n(busy_n), .i_bus_error_in_n(err_n), .o_bus_owned_n(owned_n),
        .o_addr_data_bus(ad_out), .o_addr_data_low_byte_oe(lo_oe),
        .o_addr_data_high_byte_oe(hi_oe), .i_addr_data_bus(ad_pin),
        .o_data_direction(dir), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
        .o_strobe_oe(sto_oe), .o_byte_high_enable_n(bhe_n), .o_byte_high_enable_oe(bhe_oe),
        .i_byte_high_enable(bhe_pin), .o_address_latch_enable(ale),
        .i_slave_ready_n(rdy_n), .o_transceiver_enable_n(xcvr_n));
    bus_partner bus_partner_inst (.i_bclk(bclk), .i_hreq(hreq), .i_ad(ad_out),
        .i_lo_oe(lo_oe), .i_hi_oe(hi_oe), .i_rd_n(rd_pin), .i_wr_n(wr_pin), .i_ale(ale),
        .i_waits(waits), .o_ack(ack), .o_ready_n(rdy_n), .o_ad(ad_pin),
        .o_addr(addr_seen), .o_wdata(wr_seen));
    // snapshots of the pins at the moments that matter
    always @(negedge ale) {bhe_seen, dir_seen} = {bhe_pin, dir};
    always @(posedge wr_pin) oe_seen = {hi_oe, lo_oe};
    always @(negedge owned_n) @(posedge bclk) ext_seen = ad_pin;
    always @(negedge owned_n) arb_seen = {busy_n, err_n};
    always @(posedge bclk) if (!rd_pin || !wr_pin) xcvr_seen = xcvr_n;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // one job, then every pin snapshot against what the job implies
    task automatic job(input logic [23:0] a, input logic w, wd, b8, input logic [15:0] d);
        logic [15:0] m;
        m = b8 ? 16'h00FF : (wd ? 16'hFFFF : (a[0] ? 16'hFF00 : 16'h00FF));
        xcvr_seen = 1'b1;
        @(posedge i_clk) #1;
        {req_addr, req_write, req_word, bus_8bit, req_wdata} = {a, w, wd, b8, d};
        req_valid = 1;
        @(posedge i_clk) #1;
        req_valid = 0;
        chk({15'h0, req_ready}, 16'h0000);
        do @(posedge i_clk) #1; while (done !== 1'b1);
        chk({14'h0, arb_seen}, 16'h0003);
        chk({15'h0, xcvr_seen}, 16'h0000);
        chk(ext_seen, {a[15:8], a[23:16]});
        chk(addr_seen, a[15:0]);
        chk({15'h0, bhe_seen}, {15'h0, b8 | (!wd & !a[0])});
        chk({15'h0, dir_seen}, {15'h0, w});
        if (w) chk(wr_seen & m, d & m);
        if (w) chk({14'h0, oe_seen}, {14'h0, m[15], m[0]});
        if (!w) chk(rd_data & m, ~a[15:0] & m);
        chk({13'h0, req_ready, hreq, xcvr_n}, 16'h0005);
    endtask : job
    task automatic end_of_test;
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        repeat (5) @(posedge bclk);
        #1 i_rst = 0;
        waits = 2'h3;
        job(24'hFEDCBA, 1, 1, 0, 16'hA55A);
        job(24'h000001, 0, 0, 0, 16'h0000);
        waits = 2'h0;
        job(24'hFFFFFF, 0, 1, 0, 16'h0000);
        busy_n = 0;
        err_n = 0;
        fork
            job(24'h123456, 1, 0, 1, 16'h00C3);
            begin
                repeat (100) @(posedge i_clk);
                #1 busy_n = 1;
                repeat (100) @(posedge i_clk);
                #1 err_n = 1;
            end
        join
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            waits = seed[25:24];
            job(seed[23:0], seed[26], seed[27] & !seed[28], seed[28], seed[31:16]);
        end
        end_of_test;
    end
endmodule : testbench
